// [rtl/flash_row_write_erase_control.sv]
// flash row erase, latch load and row program sequencer with wishbone registers
// Summary of operation
// - erase or program start while address points at protected location sets the error flag
// - a device reset during a running erase or program sets the error flag
// - interrupting the unlock sequence sets the error flag
// - software may write the error flag to one for testing
// - error flag stays set until software clears it; in hardware only rst_i clears it, a device reset never does
// - erase select erases the whole addressed 32-word row, data ignored
// - protected erase or program clears start, flags error, leaves flash unchanged
// - latch-load copies the 14-bit data pair into the latch chosen by address
// - latch-load ignores protection and never touches the flash array
// - program writes all latches into the addressed row, data ignored
// - after programming every latch returns to 3FFh
//
// Our own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
module flash_row_write_erase_control
	import flash_ctrl_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// device reset other than power-on, asynchronous to clk_i
	input  wire logic        device_reset_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [5:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// status
	output logic             irq_o,
	output logic             busy_o
);

	localparam int ROW_W = ADDR_W - LATCH_IDX_W;
	localparam int HI_W  = ADDR_W - 8;
	localparam int DEPTH = 1 << ADDR_W;

	ctrl_t                  ctrl_reg;
	op_state_t              state_reg;
	unlock_state_t          unlock_reg;
	logic [7:0]             addr_low_reg;
	logic [HI_W-1:0]        addr_high_reg;
	logic [7:0]             data_low_reg;
	logic [5:0]             data_high_reg;
	logic [IRQ_W-1:0]       irq_stat_reg;
	logic [IRQ_W-1:0]       irq_mask_reg;
	logic [ADDR_W-1:0]      prot_lim_reg;
	logic [ROW_W-1:0]       row_reg;
	logic [LATCH_IDX_W-1:0] step_reg;
	op_state_t              state_next;
	logic [LATCH_IDX_W-1:0] step_next;
	logic [ROW_W-1:0]       row_next;
	logic [31:0]            dat_reg;
	logic                   ack_reg;
	logic                   irq_reg;
	logic                   busy_reg;
	logic                   dev_rst_meta_reg;
	logic                   dev_rst_sync_reg;
	logic [WORD_W-1:0]      latch_reg [ROW_WORDS];
	logic [WORD_W-1:0]      program_flash_array [DEPTH];

	// bus decode
	wire                    req       = wb_cyc_i & wb_stb_i;
	wire                    wr        = req & wb_we_i & ack_reg & wb_sel_i[0];
	wire                    wr_b1     = req & wb_we_i & ack_reg & wb_sel_i[1];
	wire                    sel_ctrl  = (wb_adr_i == OFS_CTRL);
	wire                    ctrl_wr   = wr & sel_ctrl;
	wire                    unlock_wr = wr & (wb_adr_i == OFS_UNLOCK);
	wire [7:0]              wd        = wb_dat_i[7:0];

	// address split
	wire [ADDR_W-1:0]       flash_address = {addr_high_reg, addr_low_reg};
	wire [LATCH_IDX_W-1:0]  latch_sel = flash_address[LATCH_IDX_W-1:0];
	wire [ROW_W-1:0]        row_sel   = flash_address[ADDR_W-1:LATCH_IDX_W];
	wire [ADDR_W-1:0]       row_base  = {row_sel, {LATCH_IDX_W{1'b0}}};
	// protection covers whole rows below the limit, so a row is never half protected
	wire                    protected_row = (row_base < prot_lim_reg);

	// reset abort: a device reset stops a running operation
	wire                    idle      = (state_reg == ST_IDLE);
	wire                    abort     = dev_rst_sync_reg & ~idle;

	// start decode
	wire                    start_req = ctrl_wr & wd[CTRL_START_BIT] & idle & ~dev_rst_sync_reg;
	wire                    want_erase = wd[CTRL_ERASE_BIT];
	wire                    want_latch = ~wd[CTRL_ERASE_BIT] & wd[CTRL_LATCH_LOAD_ONLY_BIT];
	wire                    armed     = (unlock_reg == UL_ARMED);
	wire                    latch_load = start_req & want_latch;
	wire                    array_req = start_req & ~want_latch & armed;
	wire                    prot_fail = array_req & protected_row;
	wire                    op_go     = array_req & ~protected_row;

	// unlock sequence tracking
	wire                    ul_step   = (unlock_reg == UL_KEY1) & unlock_wr & (wd == UNLOCK_KEY2);
	wire                    ul_use    = armed & ctrl_wr & wd[CTRL_START_BIT];
	wire                    ul_break  = wr & (unlock_reg != UL_NONE) & ~ul_step & ~ul_use;

	wire                    err_set   = prot_fail | abort | ul_break;
	wire                    last_step = (step_reg == LATCH_IDX_W'(ROW_WORDS - 1));
	wire                    op_done   = ~idle & last_step & ~dev_rst_sync_reg;

	// flash array write port
	wire                    mem_we    = ~idle & ~dev_rst_sync_reg;
	wire [ADDR_W-1:0]       mem_addr  = {row_reg, step_reg};
	wire [WORD_W-1:0]       mem_wdata = (state_reg == ST_ERASE) ? ERASED_WORD
	                                                            : latch_reg[step_reg];

	wire [IRQ_W-1:0]        irq_set   = {err_set, op_done};
	wire [IRQ_W-1:0]        irq_clr   = (wr & (wb_adr_i == OFS_IRQ_STAT)) ? wd[IRQ_W-1:0]
	                                                                      : IRQ_RESET;

	// read mux
	wire [31:0]             ctrl_rd   = {27'h0, ~idle, ctrl_reg.error, ctrl_reg.erase_select,
	                                     ctrl_reg.latch_load_only, ctrl_reg.write_start};
	wire [31:0]             rd_data   =
		sel_ctrl                         ? ctrl_rd :
		(wb_adr_i == OFS_ADDR_LOW)       ? {24'h0, addr_low_reg} :
		(wb_adr_i == OFS_ADDR_HIGH)      ? 32'(addr_high_reg) :
		(wb_adr_i == OFS_DATA_LOW)       ? {24'h0, data_low_reg} :
		(wb_adr_i == OFS_DATA_HIGH)      ? {26'h0, data_high_reg} :
		(wb_adr_i == OFS_IRQ_STAT)       ? 32'(irq_stat_reg) :
		(wb_adr_i == OFS_IRQ_MASK)       ? 32'(irq_mask_reg) :
		(wb_adr_i == OFS_PROT_LIM)       ? 32'(prot_lim_reg) :
		(wb_adr_i == OFS_READ_DATA)      ? 32'(program_flash_array[flash_address]) :
		                                   32'h0000_0000;

	// device reset synchroniser
	// the reset comes from another domain; only the second stage feeds logic
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dev_rst_meta_reg <= 1'b0;
			dev_rst_sync_reg <= 1'b0;
		end else begin
			dev_rst_meta_reg <= device_reset_i;
			dev_rst_sync_reg <= dev_rst_meta_reg;
		end
	end

	// bus answer: ack one cycle after the request, dropped the cycle after
	// read data is captured at the request edge, so it is zero whenever ack is low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req & ~ack_reg;
			dat_reg <= (req & ~ack_reg & ~wb_we_i) ? rd_data : 32'h0000_0000;
		end
	end

	// plain data registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_low_reg  <= ADDR_RESET;
			addr_high_reg <= HI_W'(ADDR_RESET);
			data_low_reg  <= DATA_RESET;
			data_high_reg <= DATA_RESET[5:0];
			irq_mask_reg  <= IRQ_RESET;
			prot_lim_reg  <= ADDR_W'(PROT_RESET);
		end else begin
			if (wr & (wb_adr_i == OFS_ADDR_LOW) & idle)
				addr_low_reg <= wd;
			if (wr & (wb_adr_i == OFS_ADDR_HIGH) & idle)
				addr_high_reg <= wb_dat_i[HI_W-1:0];
			if (wr & (wb_adr_i == OFS_DATA_LOW))
				data_low_reg <= wd;
			if (wr & (wb_adr_i == OFS_DATA_HIGH))
				data_high_reg <= wd[5:0];
			if (wr & (wb_adr_i == OFS_IRQ_MASK))
				irq_mask_reg <= wd[IRQ_W-1:0];
			if (wr & (wb_adr_i == OFS_PROT_LIM))
				prot_lim_reg[7:0] <= wd;
			if (wr_b1 & (wb_adr_i == OFS_PROT_LIM))
				prot_lim_reg[ADDR_W-1:8] <= wb_dat_i[ADDR_W-1:8];
		end
	end

	// control register; the error flag survives device resets on purpose
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= CTRL_RESET;
		end else begin
			if (err_set)
				ctrl_reg.error <= 1'b1;
			else if (ctrl_wr)
				ctrl_reg.error <= wd[CTRL_ERROR_BIT];
			if (ctrl_wr & idle) begin
				ctrl_reg.erase_select    <= wd[CTRL_ERASE_BIT];
				ctrl_reg.latch_load_only <= wd[CTRL_LATCH_LOAD_ONLY_BIT];
			end
			// start stays high only while an array operation runs
			if (op_go)
				ctrl_reg.write_start <= 1'b1;
			else if (op_done | abort)
				ctrl_reg.write_start <= 1'b0;
		end
	end

	// unlock tracker
	// a repeated first key restarts the sequence; any other write drops it
	always_ff @(posedge clk_i) begin
		if (rst_i | dev_rst_sync_reg)
			unlock_reg <= UL_NONE;
		else if (unlock_wr & (wd == UNLOCK_KEY1))
			unlock_reg <= UL_KEY1;
		else if (ul_step)
			unlock_reg <= UL_ARMED;
		else if (wr)
			unlock_reg <= UL_NONE;
	end

	// operation sequencer: one word per cycle across the row
	always_comb begin
		state_next = state_reg;
		step_next  = step_reg;
		row_next   = row_reg;
		unique case (state_reg)
			ST_IDLE: begin
				step_next = '0;
				if (op_go) begin
					state_next = want_erase ? ST_ERASE : ST_PROGRAM;
					row_next   = row_sel;
				end
			end
			ST_ERASE, ST_PROGRAM: begin
				if (abort | op_done) begin
					state_next = ST_IDLE;
					step_next  = '0;
				end else begin
					step_next = step_reg + LATCH_IDX_W'(1);
				end
			end
			default: begin
				state_next = ST_IDLE;
				step_next  = '0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			step_reg  <= '0;
			row_reg   <= '0;
		end else begin
			state_reg <= state_next;
			step_reg  <= step_next;
			row_reg   <= row_next;
		end
	end

	// flash array; no reset, it is non-volatile storage
	always_ff @(posedge clk_i) begin
		if (mem_we)
			program_flash_array[mem_addr] <= mem_wdata;
	end

	// write latches
	generate
		for (genvar i = 0; i < ROW_WORDS; i++) begin : g_latch
			always_ff @(posedge clk_i) begin
				if (rst_i)
					latch_reg[i] <= LATCH_RESET;
				else if ((state_reg == ST_PROGRAM) & op_done)
					latch_reg[i] <= LATCH_RESET;
				else if (latch_load & (latch_sel == LATCH_IDX_W'(i)))
					latch_reg[i] <= {data_high_reg, data_low_reg};
			end
		end
	endgenerate

	// interrupt status: set wins over a write-one clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_reg <= IRQ_RESET;
			irq_reg      <= 1'b0;
			busy_reg     <= 1'b0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
			irq_reg      <= |(irq_stat_reg & irq_mask_reg);
			// busy falls on the edge that writes the last word, never a cycle late
			busy_reg     <= op_go | (~idle & ~op_done & ~abort);
		end
	end

	assign wb_dat_o = dat_reg;
	assign wb_ack_o = ack_reg;
	assign irq_o    = irq_reg;
	assign busy_o   = busy_reg;

endmodule : flash_row_write_erase_control

// [rtl/flash_ctrl_pkg.sv]
// constants, register map and types for the flash row write/erase controller
package flash_ctrl_pkg;

	// register byte offsets on the wishbone bus
	localparam logic [5:0] OFS_CTRL      = 6'h00;
	localparam logic [5:0] OFS_ADDR_LOW  = 6'h04;
	localparam logic [5:0] OFS_ADDR_HIGH = 6'h08;
	localparam logic [5:0] OFS_DATA_LOW  = 6'h0C;
	localparam logic [5:0] OFS_DATA_HIGH = 6'h10;
	localparam logic [5:0] OFS_UNLOCK    = 6'h14;
	localparam logic [5:0] OFS_IRQ_STAT  = 6'h18;
	localparam logic [5:0] OFS_IRQ_MASK  = 6'h1C;
	localparam logic [5:0] OFS_PROT_LIM  = 6'h20;
	localparam logic [5:0] OFS_READ_DATA = 6'h24;

	// control register bit positions
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_LATCH_LOAD_ONLY_BIT  = 1;
	localparam int CTRL_ERASE_BIT = 2;
	localparam int CTRL_ERROR_BIT = 3;
	localparam int CTRL_BUSY_BIT  = 4;

	// interrupt status bit positions
	localparam int IRQ_DONE_BIT  = 0;
	localparam int IRQ_ERROR_BIT = 1;
	localparam int IRQ_W         = 2;

	// unlock keys, written in this order
	localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
	localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;

	// array geometry and word values
	localparam int          WORD_W      = 14;
	localparam int          ROW_WORDS   = 32;
	localparam int          LATCH_IDX_W = 5;
	localparam logic [13:0] LATCH_RESET = 14'h03FF;
	localparam logic [13:0] ERASED_WORD = 14'h3FFF;

	// reset values
	localparam logic [7:0]      ADDR_RESET   = 8'h00;
	localparam logic [7:0]      DATA_RESET   = 8'h00;
	localparam logic [IRQ_W-1:0] IRQ_RESET   = 2'h0;
	localparam logic [15:0]     PROT_RESET   = 16'h0000;

	typedef struct packed {
		logic error;
		logic erase_select;
		logic latch_load_only;
		logic write_start;
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = '{error: 1'b0, erase_select: 1'b0,
		latch_load_only: 1'b0, write_start: 1'b0};

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_ERASE   = 2'b01,
		ST_PROGRAM = 2'b10
	} op_state_t;

	typedef enum logic [1:0] {
		UL_NONE  = 2'b00,
		UL_KEY1  = 2'b01,
		UL_ARMED = 2'b11
	} unlock_state_t;

endpackage : flash_ctrl_pkg

// [dv/flash_row_write_erase_control_assertions.sv]
// port-level checks for the flash row sequencer
`timescale 1ns/10ps
module flash_row_write_erase_control_assertions
	import flash_ctrl_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        device_reset_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [5:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        irq_o,
	input wire logic        busy_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_wr(logic [5:0] a);
		wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == a;
	endsequence
	a_ack_follows_req: assert property (s_req |=> wb_ack_o) else $error("no ack");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not zero");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > OFS_READ_DATA
		|-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	a_busy_row_len: assert property (disable iff (rst_i || device_reset_i)
		$rose(busy_o) |-> busy_o [*8] ##24 busy_o ##1 !busy_o) else $error("busy length");
	a_latch_no_busy: assert property (s_wr(OFS_CTRL) ##0 (wb_dat_i[2:0] == 3'h3 && !busy_o)
		|=> !busy_o [*3]) else $error("latch load touched array");
	a_reset_abort: assert property ($rose(device_reset_i) && busy_o
		|-> ##[1:5] !busy_o) else $error("reset did not abort");
	a_mask_quiet: assert property (s_wr(OFS_IRQ_MASK) ##0 (wb_dat_i[1:0] == 2'h0)
		|-> ##2 !irq_o) else $error("masked irq high");
	a_reset_quiet: assert property (disable iff (1'b0)
		rst_i |=> !busy_o && !irq_o && !wb_ack_o) else $error("outputs active in reset");
endmodule : flash_row_write_erase_control_assertions

bind flash_row_write_erase_control flash_row_write_erase_control_assertions #(.ADDR_W(ADDR_W))
	chk (.clk_i(clk_i), .rst_i(rst_i), .device_reset_i(device_reset_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
	.busy_o(busy_o));

// [dv/flash_row_write_erase_control_test.sv]
// self-checking bench for the flash row sequencer
`timescale 1ns/10ps
module flash_row_write_erase_control_test;
	import flash_ctrl_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        device_reset_i = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [5:0]  wb_adr_i = 6'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        irq_o;
	logic        busy_o;
	logic [31:0] exp_q[$];
	logic [15:0] lfsr = 16'h07C2;
	logic [13:0] d0;
	logic [13:0] d1;
	int          fails = 0;
	int          n_checks = 0;
	always #4 clk_i = ~clk_i;
	flash_row_write_erase_control #(.ADDR_W(12)) uut (.clk_i(clk_i), .rst_i(rst_i),
		.device_reset_i(device_reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .busy_o(busy_o));
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr_next
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run;
		if (fails == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run
	// one classic cycle; the request stands until ack is sampled high
	task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hF;
		wb_dat_i <= d;
		@(posedge clk_i iff wb_ack_o === 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd
	task automatic setadr(input logic [11:0] a);
		wr(OFS_ADDR_LOW, {24'h0, a[7:0]});
		wr(OFS_ADDR_HIGH, {28'h0, a[11:8]});
	endtask : setadr
	task automatic setdat(input logic [13:0] w);
		wr(OFS_DATA_LOW, {24'h0, w[7:0]});
		wr(OFS_DATA_HIGH, {26'h0, w[13:8]});
	endtask : setdat
	task automatic wait_idle;
		repeat (2) @(posedge clk_i);
		while (busy_o !== 1'b0) @(posedge clk_i);
	endtask : wait_idle
	task automatic go(input logic [31:0] c);
		wr(OFS_UNLOCK, {24'h0, UNLOCK_KEY1});
		wr(OFS_UNLOCK, {24'h0, UNLOCK_KEY2});
		wr(OFS_CTRL, c);
	endtask : go
	task automatic rword(input logic [11:0] a, input logic [13:0] w);
		setadr(a);
		rd(OFS_READ_DATA, {18'h0, w});
	endtask : rword
	// read answers are compared in the order their expectations were noted
	always @(posedge clk_i)
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
			check(wb_dat_o, exp_q.pop_front());
	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		complete_run();
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(OFS_CTRL, 32'h0);
		rd(6'h28, 32'h0);
		// row 0 starts erased so a refused program can be seen to leave it alone
		setadr(12'h000);
		go(32'h5);
		wait_idle();
		wr(OFS_PROT_LIM, 32'h20);
		lfsr = lfsr_next(lfsr);
		d0 = lfsr[13:0];
		lfsr = lfsr_next(lfsr);
		d1 = lfsr[13:0];
		// latch loads aimed at the protected row still land
		setadr(12'h005);
		setdat(d0);
		wr(OFS_CTRL, 32'h3);
		setadr(12'h01F);
		setdat(d1);
		wr(OFS_CTRL, 32'h3);
		rd(OFS_CTRL, 32'h2);
		setadr(12'h02A);
		go(32'h1);
		@(negedge clk_i);
		check({31'h0, busy_o}, 32'h1);
		wait_idle();
		rword(12'h025, d0);
		rword(12'h03F, d1);
		rword(12'h020, LATCH_RESET);
		setadr(12'h040);
		go(32'h1);
		wait_idle();
		rword(12'h05F, LATCH_RESET);
		setadr(12'h03F);
		go(32'h7);
		wait_idle();
		rword(12'h025, ERASED_WORD);
		setadr(12'h005);
		go(32'h1);
		@(negedge clk_i);
		check({31'h0, busy_o}, 32'h0);
		wait_idle();
		rd(OFS_CTRL, 32'h8);
		rword(12'h005, ERASED_WORD);
		wr(OFS_ADDR_LOW, 32'h0);
		rd(OFS_CTRL, 32'h8);
		wr(OFS_CTRL, 32'h0);
		rd(OFS_CTRL, 32'h0);
		wr(OFS_CTRL, 32'h8);
		rd(OFS_CTRL, 32'h8);
		wr(OFS_CTRL, 32'h0);
		setadr(12'h060);
		go(32'h5);
		repeat (4) @(posedge clk_i);
		device_reset_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		device_reset_i <= 1'b0;
		wait_idle();
		rd(OFS_CTRL, 32'hC);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_UNLOCK, {24'h0, UNLOCK_KEY1});
		wr(OFS_DATA_LOW, 32'h0);
		rd(OFS_CTRL, 32'h8);
		rd(OFS_IRQ_STAT, 32'h3);
		wr(OFS_IRQ_MASK, 32'h2);
		@(negedge clk_i);
		check({31'h0, irq_o}, 32'h1);
		@(posedge clk_i);
		wr(OFS_IRQ_STAT, 32'h2);
		@(negedge clk_i);
		check({31'h0, irq_o}, 32'h0);
		@(posedge clk_i);
		rd(OFS_IRQ_STAT, 32'h1);
		wr(OFS_IRQ_MASK, 32'h0);
		@(negedge clk_i);
		check({31'h0, irq_o}, 32'h0);
		repeat (2) @(posedge clk_i);
		complete_run();
	end
endmodule : flash_row_write_erase_control_test
